// ---- rtl/epmc_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - management clock divided, at most 2.5 MHz
// - negotiation enable reads set after reset
// - advertisement word sent as link pulses
// - diagnostic shows resolved duplex and speed
// - failure sets flag, negotiation stays in send
// - restart bit restarts negotiation
// - auto polarity: bit reports detected inversion
// - manual mode applies the polarity bit
// - power down; management still answered
// - receive power save, wakes on signal
// - indicators driven only in alternate function
// - mac event interrupt sources
// - phy event interrupt source
// - transmit request cleared when transmission done
// - packet count and fifo data readable
// - raw status read, write one clears
module epmc_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic [epmc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [31:0]                 wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [31:0]                 rdata_out,
  input  wire logic [4:0]                  mac_event_in,
  input  wire logic                        tx_done_in,
  input  wire logic [5:0]                  packet_count_in,
  input  wire logic [31:0]                 fifo_rdata_in,
  output logic                             fifo_wr_out,
  output logic                             fifo_rd_out,
  output logic      [31:0]                 fifo_wdata_out,
  output logic      [4:0]                  transmit_control_out,
  output logic      [4:0]                  receive_control_out,
  output logic      [47:0]                 station_address_out,
  output logic                             transmit_request_out,
  output logic                             irq_out,
  output logic                             mdc_out,
  input  wire logic [epmc_pkg::PIN_W-1:0]  phy_pins_in,
  output logic                             flp_send_out,
  output logic      [15:0]                 flp_word_out,
  output logic                             rx_invert_out,
  output logic                             rx_powered_out,
  output logic                             phy_power_down_out,
  output logic                             indicator_a_out,
  output logic                             indicator_a_oe_b_out,
  output logic                             indicator_b_out,
  output logic                             indicator_b_oe_b_out
);
  import epmc_pkg::*;

  epmc_mgmt_if mg ();

  epmc_mg_t         mg_state;
  logic [IRQ_W-1:0] ris_reg, im_reg, irq_set;
  logic [7:0]       mdv_reg, eff_div, div_cnt_reg, gap_cnt_reg;
  logic [15:0]      mctl_reg, mtxd_reg, mrxd_reg;
  logic [5:0]       bit_cnt_reg;
  logic [1:0]       pinsel_reg, led_state;
  logic [PIN_W-1:0] pin_sync;
  logic             phy_int_d_reg, mg_tick, mg_last;
  logic             wr_ris, wr_mctl, wr_tr, wr_data;

  // pin synchronisers
  for (genvar gi = 0; gi < PIN_W; gi++) begin : g_sync
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else begin
        meta_reg <= phy_pins_in[gi];
        sync_reg <= meta_reg;
      end
    end
    assign pin_sync[gi] = sync_reg;
  end

  assign wr_ris  = wr_in && addr_in == OFF_RIS;
  assign wr_mctl = wr_in && addr_in == OFF_MCTL;
  assign wr_tr   = wr_in && addr_in == OFF_TR;
  assign wr_data = wr_in && addr_in == OFF_DATA;

  // control registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      im_reg               <= IM_RST;
      receive_control_out  <= RCTL_RST;
      transmit_control_out <= 5'h00;
      station_address_out  <= 48'h0;
      mdv_reg              <= MDV_RST;
      mtxd_reg             <= 16'h0000;
      pinsel_reg           <= 2'h0;
    end else if (wr_in) begin
      unique case (addr_in)
        OFF_IM:     im_reg <= wdata_in[IRQ_W-1:0];
        OFF_RCTL:   receive_control_out <= wdata_in[4:0];
        OFF_TCTL:   transmit_control_out <= wdata_in[4:0];
        OFF_IA0:    station_address_out[31:0] <= wdata_in;
        OFF_IA1:    station_address_out[47:32] <= wdata_in[15:0];
        OFF_MDV:    mdv_reg <= wdata_in[7:0];
        OFF_MTXD:   mtxd_reg <= wdata_in[15:0];
        OFF_PINSEL: pinsel_reg <= wdata_in[1:0];
        default:    pinsel_reg <= pinsel_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fifo_wr_out    <= 1'b0;
      fifo_rd_out    <= 1'b0;
      fifo_wdata_out <= 32'h0;
    end else begin
      fifo_wr_out <= wr_data;
      fifo_rd_out <= rd_in && addr_in == OFF_DATA;
      if (wr_data) fifo_wdata_out <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      transmit_request_out <= 1'b0;
    end else if (wr_tr && wdata_in[0]) begin
      transmit_request_out <= 1'b1;
    end else if (tx_done_in) begin
      transmit_request_out <= 1'b0;
    end
  end

  // read port
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h0;
    end else if (!rd_in) begin
      rdata_out <= 32'h0;
    end else begin
      unique case (addr_in)
        OFF_RIS:    rdata_out <= {25'h0, ris_reg};
        OFF_IM:     rdata_out <= {25'h0, im_reg};
        OFF_RCTL:   rdata_out <= {27'h0, receive_control_out};
        OFF_TCTL:   rdata_out <= {27'h0, transmit_control_out};
        OFF_DATA:   rdata_out <= fifo_rdata_in;
        OFF_IA0:    rdata_out <= station_address_out[31:0];
        OFF_IA1:    rdata_out <= {16'h0, station_address_out[47:32]};
        OFF_MCTL:   rdata_out <= {16'h0, mctl_reg};
        OFF_MDV:    rdata_out <= {24'h0, mdv_reg};
        OFF_MTXD:   rdata_out <= {16'h0, mtxd_reg};
        OFF_MRXD:   rdata_out <= {16'h0, mrxd_reg};
        OFF_NP:     rdata_out <= {26'h0, packet_count_in};
        OFF_TR:     rdata_out <= {31'h0, transmit_request_out};
        OFF_PINSEL: rdata_out <= {30'h0, pinsel_reg};
        default:    rdata_out <= 32'h0;
      endcase
    end
  end

  assign eff_div = mdv_reg < MDV_MIN ? MDV_MIN : mdv_reg;
  assign mg_tick = mg_state == MG_SHIFT && div_cnt_reg == eff_div;
  assign mg_last = mg_tick && mdc_out && bit_cnt_reg == 6'h01;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mg_state    <= MG_IDLE;
      div_cnt_reg <= 8'h00;
      bit_cnt_reg <= 6'h00;
      mdc_out     <= 1'b0;
    end else begin
      unique case (mg_state)
        MG_IDLE: begin
          div_cnt_reg <= 8'h00;
          mdc_out     <= 1'b0;
          if (mctl_reg[MCTL_START]) begin
            mg_state    <= MG_SHIFT;
            bit_cnt_reg <= MGMT_BITS;
          end
        end
        MG_SHIFT: begin
          if (mg_tick) begin
            div_cnt_reg <= 8'h00;
            mdc_out     <= !mdc_out;
            if (mdc_out) bit_cnt_reg <= bit_cnt_reg - 6'h01;
            if (mg_last) mg_state <= MG_IDLE;
          end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
          end
        end
        default: mg_state <= MG_IDLE;
      endcase
    end
  end

  assign mg.acc   = mg_last;
  assign mg.wr    = mctl_reg[MCTL_WRITE];
  assign mg.addr  = mctl_reg[MCTL_ADR+:5];
  assign mg.wdata = mtxd_reg;

  // management control and receive data
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mctl_reg <= 16'h0000;
      mrxd_reg <= 16'h0000;
    end else begin
      if (wr_mctl) begin
        mctl_reg <= wdata_in[15:0];
      end else if (mg_last) begin
        mctl_reg[MCTL_START] <= 1'b0;
      end
      if (mg_last && !mctl_reg[MCTL_WRITE]) mrxd_reg <= mg.rdata;
    end
  end

  assign irq_set = {mg.phy_int && !phy_int_d_reg, mg_last, mac_event_in};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ris_reg       <= '0;
      phy_int_d_reg <= 1'b0;
    end else begin
      phy_int_d_reg <= mg.phy_int;
      if (wr_ris) ris_reg <= (ris_reg & ~wdata_in[IRQ_W-1:0]) | irq_set;
      else ris_reg <= ris_reg | irq_set;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(ris_reg & im_reg);
    end
  end

  epmc_phy u_phy (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .mg             (mg.phy),
    .pins_in        (pin_sync),
    .flp_send_out   (flp_send_out),
    .flp_word_out   (flp_word_out),
    .rx_invert_out  (rx_invert_out),
    .rx_powered_out (rx_powered_out),
    .power_down_out (phy_power_down_out),
    .led_state_out  (led_state)
  );

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      indicator_a_out      <= 1'b0;
      indicator_b_out      <= 1'b0;
      indicator_a_oe_b_out <= 1'b1;
      indicator_b_oe_b_out <= 1'b1;
    end else begin
      indicator_a_out      <= pinsel_reg[0] & led_state[0];
      indicator_b_out      <= pinsel_reg[1] & led_state[1];
      indicator_a_oe_b_out <= !pinsel_reg[0];
      indicator_b_oe_b_out <= !pinsel_reg[1];
    end
  end

  // gap since last management clock edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_cnt_reg <= 8'h00;
    end else if ($changed(mdc_out)) begin
      gap_cnt_reg <= 8'h01;
    end else if (gap_cnt_reg != 8'hff) begin
      gap_cnt_reg <= gap_cnt_reg + 8'h01;
    end
  end

  a_mdc_rate: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $changed(mdc_out) && gap_cnt_reg != 8'h00 |-> gap_cnt_reg > MDV_MIN)
    else $error("management clock too fast");

  a_ris_set_wins: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    mac_event_in[0] |=> ris_reg[0])
    else $error("event lost against clear");

  a_ris_clear: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    wr_ris && wdata_in[1] && !mac_event_in[1] |=> !ris_reg[1])
    else $error("write one did not clear");

  a_irq_masked: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (im_reg == '0) ##1 (im_reg == '0) |-> !irq_out)
    else $error("masked status reached interrupt");

  a_irq_raise: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    mac_event_in[2] && im_reg[2] && !wr_ris ##1 im_reg[2] |=> irq_out)
    else $error("unmasked event gave no interrupt");

  a_mdint_done: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    mg_last && !wr_mctl |=> ris_reg[IRQ_MDINT] && !mctl_reg[MCTL_START])
    else $error("management completion not flagged");

  a_tr_clear: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    tx_done_in && !wr_tr |=> !transmit_request_out)
    else $error("transmit request not cleared");

  a_np_read: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    rd_in && addr_in == OFF_NP |=>
      rdata_out == {26'h0, $past(packet_count_in)})
    else $error("packet count read wrong");

  a_led_gpio: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !pinsel_reg[0] |=> indicator_a_oe_b_out && !indicator_a_out)
    else $error("indicator driven in gpio mode");
endmodule : epmc_top

// ---- rtl/epmc_pkg.sv ----
package epmc_pkg;
  localparam int ADDR_W = 8;
  localparam int PIN_W  = 11;
  localparam int IRQ_W  = 7;
  localparam logic [7:0] OFF_RIS    = 8'h00;
  localparam logic [7:0] OFF_IM     = 8'h04;
  localparam logic [7:0] OFF_RCTL   = 8'h08;
  localparam logic [7:0] OFF_TCTL   = 8'h0c;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_IA0    = 8'h14;
  localparam logic [7:0] OFF_IA1    = 8'h18;
  localparam logic [7:0] OFF_MCTL   = 8'h20;
  localparam logic [7:0] OFF_MDV    = 8'h24;
  localparam logic [7:0] OFF_MTXD   = 8'h2c;
  localparam logic [7:0] OFF_MRXD   = 8'h30;
  localparam logic [7:0] OFF_NP     = 8'h34;
  localparam logic [7:0] OFF_TR     = 8'h38;
  localparam logic [7:0] OFF_PINSEL = 8'h3c;
  localparam logic [6:0] IM_RST   = 7'h7f;
  localparam logic [4:0] RCTL_RST = 5'h08;
  localparam logic [7:0] MDV_RST  = 8'h80;
  localparam int IRQ_MDINT = 5;
  localparam int IRQ_PHY   = 6;
  localparam int MCTL_START = 0;
  localparam int MCTL_WRITE = 1;
  localparam int MCTL_ADR   = 3;
  localparam int CLK_KHZ     = 100000;
  localparam int MDC_MAX_KHZ = 2500;
  localparam logic [7:0] MDV_MIN =
    8'((CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ) - 1);
  localparam logic [5:0] MGMT_BITS = 6'h20;
  localparam logic [4:0] PHY_CTL  = 5'h00;
  localparam logic [4:0] PHY_STAT = 5'h01;
  localparam logic [4:0] PHY_ADV  = 5'h04;
  localparam logic [4:0] PHY_VEND = 5'h10;
  localparam logic [4:0] PHY_IRQ  = 5'h11;
  localparam logic [4:0] PHY_DIAG = 5'h12;
  localparam logic [4:0] PHY_LED  = 5'h17;
  localparam logic [15:0] CTL_RST  = 16'h3100;
  localparam logic [15:0] ADV_RST  = 16'h01e1;
  localparam logic [15:0] VEND_RST = 16'h0140;
  localparam logic [15:0] LED_RST  = 16'h0010;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_RESTART = 9;
  localparam int CTL_PHY_POWER_DOWN = 11;
  localparam int CTL_ANEN = 12;
  localparam int CTL_SPEED = 13;
  localparam int STAT_LINK = 2;
  localparam int STAT_ANDONE = 5;
  localparam int ADV_10FD = 6;
  localparam int ADV_100 = 7;
  localparam int ADV_100FD = 8;
  localparam int VEND_RECEIVE_POWER_SAVE = 0;
  localparam int VEND_POLBIT = 4;
  localparam int VEND_POLMODE = 5;
  localparam int DIAG_RATE = 10;
  localparam int DIAG_DUPLEX_FLAG = 11;
  localparam int DIAG_FAIL = 12;
  localparam int LED_A_LSB = 0;
  localparam int LED_B_LSB = 4;
  localparam int PIN_LINK = 0;
  localparam int PIN_ACK = 1;
  localparam int PIN_FAIL = 2;
  localparam int PIN_FD = 3;
  localparam int PIN_100 = 4;
  localparam int PIN_RFLT = 5;
  localparam int PIN_PDF = 6;
  localparam int PIN_RXERR = 7;
  localparam int PIN_JAB = 8;
  localparam int PIN_SIG = 9;
  localparam int PIN_POLINV = 10;
  typedef enum logic [2:0] {
    NEG_OFF  = 3'b001,
    NEG_SEND = 3'b010,
    NEG_DONE = 3'b100
  } epmc_neg_t;
  typedef enum logic [1:0] {
    MG_IDLE  = 2'b01,
    MG_SHIFT = 2'b10
  } epmc_mg_t;
endpackage : epmc_pkg

// ---- rtl/epmc_mgmt_if.sv ----
`timescale 1ns/1ps
interface epmc_mgmt_if;
  logic        acc;
  logic        wr;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        phy_int;
  modport mac (output acc, wr, addr, wdata, input rdata, phy_int);
  modport phy (input acc, wr, addr, wdata, output rdata, phy_int);
endinterface : epmc_mgmt_if

// ---- rtl/epmc_phy.sv ----
`timescale 1ns/1ps
module epmc_phy (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  epmc_mgmt_if.phy                        mg,
  input  wire logic [epmc_pkg::PIN_W-1:0] pins_in,
  output logic                            flp_send_out,
  output logic [15:0]                     flp_word_out,
  output logic                            rx_invert_out,
  output logic                            rx_powered_out,
  output logic                            power_down_out,
  output logic [1:0]                      led_state_out
);
  import epmc_pkg::*;
  epmc_neg_t   neg_state;
  logic [15:0] ctl_reg, adv_reg, vend_reg, led_reg, diag_reg, stat;
  logic [7:0]  irq_reg, irq_set;
  logic [PIN_W-1:0] prev_reg, rise;
  logic        wr, restart, done_go, rate, duplex_flag, polmode;
  logic [3:0]  led_src;

  assign wr = mg.acc && mg.wr;
  assign restart = wr && mg.addr == PHY_CTL && mg.wdata[CTL_RESTART];
  assign rise = pins_in & ~prev_reg;
  assign done_go = neg_state == NEG_SEND && pins_in[PIN_ACK]
                   && pins_in[PIN_LINK];
  assign polmode = vend_reg[VEND_POLMODE];
  assign rate = (adv_reg[ADV_100] | adv_reg[ADV_100FD]) & pins_in[PIN_100];
  assign duplex_flag = pins_in[PIN_FD] & (rate ? adv_reg[ADV_100FD]
                                        : adv_reg[ADV_10FD]);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_reg  <= CTL_RST;
      adv_reg  <= ADV_RST;
      vend_reg <= VEND_RST;
      led_reg  <= LED_RST;
    end else if (wr) begin
      if (mg.addr == PHY_CTL) begin
        ctl_reg <= mg.wdata & ~(16'h0001 << CTL_RESTART);
      end
      if (mg.addr == PHY_ADV) adv_reg <= mg.wdata;
      if (mg.addr == PHY_VEND) vend_reg <= mg.wdata;
      if (mg.addr == PHY_LED) led_reg <= mg.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      neg_state <= NEG_SEND;
    end else if (!ctl_reg[CTL_ANEN] || ctl_reg[CTL_PHY_POWER_DOWN]) begin
      neg_state <= NEG_OFF;
    end else if (restart) begin
      neg_state <= NEG_SEND;
    end else begin
      unique case (neg_state)
        NEG_OFF:  neg_state <= NEG_SEND;
        NEG_SEND: if (done_go) neg_state <= NEG_DONE;
        NEG_DONE: if (!pins_in[PIN_LINK]) neg_state <= NEG_SEND;
        default:  neg_state <= NEG_SEND;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      diag_reg <= 16'h0000;
    end else begin
      if (neg_state == NEG_OFF) begin
        diag_reg[DIAG_RATE] <= ctl_reg[CTL_SPEED];
        diag_reg[DIAG_DUPLEX_FLAG] <= ctl_reg[CTL_DUPLEX];
      end else if (done_go) begin
        diag_reg[DIAG_RATE] <= rate;
        diag_reg[DIAG_DUPLEX_FLAG] <= duplex_flag;
      end
      if (neg_state == NEG_SEND && pins_in[PIN_FAIL]) begin
        diag_reg[DIAG_FAIL] <= 1'b1;
      end else if (restart || done_go) begin
        diag_reg[DIAG_FAIL] <= 1'b0;
      end
    end
  end

  assign irq_set = {rise[PIN_JAB], rise[PIN_RXERR], rise[PIN_ACK],
                    rise[PIN_PDF], rise[PIN_ACK],
                    pins_in[PIN_LINK] ^ prev_reg[PIN_LINK],
                    rise[PIN_RFLT], done_go};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_reg    <= '0;
      irq_reg     <= 8'h00;
      mg.phy_int  <= 1'b0;
    end else begin
      prev_reg <= pins_in;
      if (mg.acc && !mg.wr && mg.addr == PHY_IRQ) irq_reg <= irq_set;
      else irq_reg <= irq_reg | irq_set;
      mg.phy_int <= |irq_reg;
    end
  end

  assign led_src = {flp_send_out, diag_reg[DIAG_DUPLEX_FLAG],
                    diag_reg[DIAG_RATE], pins_in[PIN_LINK]};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_invert_out  <= 1'b0;
      rx_powered_out <= 1'b0;
      power_down_out <= 1'b0;
      led_state_out  <= 2'h0;
    end else begin
      rx_invert_out  <= polmode ? vend_reg[VEND_POLBIT]
                                : pins_in[PIN_POLINV];
      rx_powered_out <= !ctl_reg[CTL_PHY_POWER_DOWN] &&
                        (!vend_reg[VEND_RECEIVE_POWER_SAVE] || pins_in[PIN_SIG]);
      power_down_out <= ctl_reg[CTL_PHY_POWER_DOWN];
      led_state_out  <= {led_src[led_reg[LED_B_LSB+:2]],
                         led_src[led_reg[LED_A_LSB+:2]]};
    end
  end

  assign flp_send_out = neg_state[1];
  assign flp_word_out = adv_reg;

  always_comb begin
    stat = 16'h0000;
    stat[STAT_LINK] = pins_in[PIN_LINK];
    stat[STAT_ANDONE] = neg_state == NEG_DONE;
    unique case (mg.addr)
      PHY_CTL:  mg.rdata = ctl_reg;
      PHY_STAT: mg.rdata = stat;
      PHY_ADV:  mg.rdata = adv_reg;
      PHY_VEND: mg.rdata = polmode ? vend_reg
                 : {vend_reg[15:5], pins_in[PIN_POLINV], vend_reg[3:0]};
      PHY_IRQ:  mg.rdata = {8'h00, irq_reg};
      PHY_DIAG: mg.rdata = diag_reg;
      PHY_LED:  mg.rdata = led_reg;
      default:  mg.rdata = 16'h0000;
    endcase
  end

  a_fail_flag: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    neg_state == NEG_SEND && pins_in[PIN_FAIL] && ctl_reg[CTL_ANEN]
    && !ctl_reg[CTL_PHY_POWER_DOWN] |=> diag_reg[DIAG_FAIL] && flp_send_out)
    else $error("negotiation failure not flagged");
  a_pol_manual: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    polmode ##1 polmode |-> rx_invert_out == $past(vend_reg[VEND_POLBIT]))
    else $error("manual polarity not applied");
  a_rx_wake: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    pins_in[PIN_SIG] && !ctl_reg[CTL_PHY_POWER_DOWN] |=> rx_powered_out)
    else $error("receive circuits did not wake");
endmodule : epmc_phy

// ---- verif/epmc_partner.sv ----
`timescale 1ns/1ps
module epmc_partner (
  input  wire logic        clk_in,
  input  wire logic        link_in,
  input  wire logic        fail_in,
  output logic      [10:0] pins_out
);
  // partner offers full duplex 100M, signal with link
  always_ff @(posedge clk_in) begin
    pins_out <= {1'b0, link_in, 4'h0, {2{link_in}}, fail_in, {2{link_in}}};
  end
endmodule : epmc_partner

// ---- verif/tb_ethernet_phy_mac_control.sv ----
`timescale 1ns/1ps
module tb_ethernet_phy_mac_control;
  import epmc_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [4:0]  mac_event_in = 5'h00;
  logic        tx_done_in = 1'b0;
  logic [5:0]  packet_count_in = 6'h00;
  logic        link = 1'b0;
  logic        fail = 1'b0;
  logic        frd, fsend, rxp, ia, ib;
  logic        mdc_q = 1'b0;
  logic [10:0] pins;
  logic [31:0] rdata_out, fwd, q;
  logic [15:0] flp;
  logic [4:0]  tctl, rctl;
  logic        fwr, treq, irq_out, mdc_out, pd, inv, oea, oeb;
  int          errors = 0;
  int          n_tests = 0;
  int          hold = 0;
  always #5 clk_in = ~clk_in;
  epmc_partner i_partner (.clk_in(clk_in), .link_in(link), .fail_in(fail),
                          .pins_out(pins));
  epmc_top i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .mac_event_in(mac_event_in),
    .tx_done_in(tx_done_in), .packet_count_in(packet_count_in),
    .fifo_rdata_in(32'h0000_00a5), .fifo_wr_out(fwr), .fifo_rd_out(frd),
    .fifo_wdata_out(fwd), .transmit_control_out(tctl),
    .receive_control_out(rctl), .station_address_out(),
    .transmit_request_out(treq), .irq_out(irq_out), .mdc_out(mdc_out),
    .phy_pins_in(pins), .flp_send_out(fsend), .flp_word_out(flp),
    .rx_invert_out(inv), .rx_powered_out(rxp), .phy_power_down_out(pd),
    .indicator_a_out(ia), .indicator_a_oe_b_out(oea),
    .indicator_b_out(ib), .indicator_b_oe_b_out(oeb));
  task automatic chk(input logic [63:0] s, input logic [63:0] e,
                     input string w);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  task automatic mg(input logic [4:0] r, input logic w, input logic [15:0] d);
    wr(OFF_MTXD, {16'h0, d});
    wr(OFF_MCTL, {24'h0, r, 1'b0, w, 1'b1});
    q = 32'h0;
    for (int i = 0; i < 1000 && q[IRQ_MDINT] !== 1'b1; i++) rd(OFF_RIS, q);
    chk(q[IRQ_MDINT], 1'b1, "mgmt done");
    wr(OFF_RIS, 32'h20);
    rd(OFF_MRXD, q);
  endtask : mg
  always @(negedge clk_in) begin
    mdc_q <= mdc_out;
    hold <= (mdc_out !== mdc_q) ? 0 : hold + 1;
    if (mdc_out !== mdc_q) chk(hold >= 19, 1'b1, "mdc half");
  end
  task automatic t_regs();
    chk({oea, oeb, fsend, flp}, {3'b111, ADV_RST}, "reset pins");
    rd(OFF_MDV, q);
    chk(q, MDV_RST, "divider");
    rd(8'h40, q);
    chk(q, 32'h0, "unmapped");
    wr(OFF_PINSEL, 32'h3);
    @(posedge clk_in);
    #1 chk({oea, oeb, ia, ib, rxp}, 5'h01, "oe_b alt");
  endtask : t_regs
  task automatic t_irq();
    @(posedge clk_in);
    mac_event_in <= 5'h1f;
    @(posedge clk_in);
    mac_event_in <= 5'h00;
    rd(OFF_RIS, q);
    chk({irq_out, q[4:0]}, 6'h3f, "raw status");
    wr(OFF_IM, 32'h0);
    repeat (2) @(posedge clk_in);
    #1 chk(irq_out, 1'b0, "masked");
    wr(OFF_RIS, 32'h0b);
    rd(OFF_RIS, q);
    chk(q[4:0], 5'h14, "w1c");
  endtask : t_irq
  task automatic t_data();
    wr(OFF_TCTL, 32'h16);
    wr(OFF_RCTL, 32'h18);
    chk({tctl, rctl}, {5'h16, 5'h18}, "ctl init");
    wr(OFF_TCTL, 32'h17);
    wr(OFF_RCTL, 32'h19);
    chk({tctl, rctl}, {5'h17, 5'h19}, "ctl enable");
    wr(OFF_DATA, 32'hcafe_0042);
    chk({fwr, fwd}, {1'b1, 32'hcafe_0042}, "fifo wr");
    wr(OFF_TR, 32'h1);
    chk(treq, 1'b1, "tx req");
    @(posedge clk_in);
    tx_done_in <= 1'b1;
    packet_count_in <= 6'h03;
    @(posedge clk_in);
    tx_done_in <= 1'b0;
    @(posedge clk_in);
    #1 chk(treq, 1'b0, "tx req clr");
    rd(OFF_NP, q);
    chk(q, 32'h3, "pkt count");
    rd(OFF_DATA, q);
    chk({frd, q}, {1'b1, 32'ha5}, "fifo rd");
  endtask : t_data
  task automatic t_phy();
    wr(OFF_MDV, 32'h0);
    mg(PHY_CTL, 1'b0, 16'h0);
    chk(q, CTL_RST, "phy ctl");
    wr(OFF_MDV, {24'h0, MDV_MIN});
    @(posedge clk_in);
    fail <= 1'b1;
    mg(PHY_VEND, 1'b1, 16'h0141);
    mg(PHY_DIAG, 1'b0, 16'h0);
    chk({fsend, rxp, q[12]}, 3'b101, "fail no signal");
    @(posedge clk_in);
    fail <= 1'b0;
    link <= 1'b1;
    mg(PHY_DIAG, 1'b0, 16'h0);
    chk({fsend, rxp, q[12:10]}, 5'h0b, "diag");
    rd(OFF_RIS, q);
    chk(q[IRQ_PHY], 1'b1, "phy irq");
    mg(PHY_VEND, 1'b1, 16'h0170);
    chk(inv, 1'b1, "manual pol");
    mg(PHY_CTL, 1'b1, 16'h3900);
    mg(PHY_CTL, 1'b0, 16'h0);
    chk({pd, rxp, ia, ib, q}, {4'hb, 32'h3900}, "power down");
  endtask : t_phy
  task automatic give_verdict();
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #500us;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    t_regs();
    t_irq();
    t_data();
    t_phy();
    give_verdict();
  end
endmodule : tb_ethernet_phy_mac_control
